//--- hw/ivt_pkg.sv
/*
  Constants, carrier types and state layout of the integer instruction
  decode and timing block. Assumes a single 200 MHz core clock.
*/
// Overview of operation
// [RULE1] 0F BE/BF with modrm is a sign-extending move; 1/3 clocks, miss 5
// [RULE2] 0F B6/B7 with modrm is a zero-extending move; 2/3 clocks, miss 5
// [RULE3] F6/F7 reg 100 multiplies unsigned: 3/5 or 7/9 clocks, miss 7 or 13
// [RULE4] F6/F7 reg 011 negates, sets six arithmetic flags; 1/3 clocks, miss 5
// [RULE5] F6/F7 reg 010 inverts all operand bits; 1/3 clocks, miss 5
// [RULE6] OR clears overflow and carry, sets others; register form takes 1 clock; the code also clears aux
// [RULE7] OR register to memory and memory to register take 3 clocks, miss 5
// [RULE8] OR immediate, 80/81 reg 001, takes 1/3 clocks, miss 5
// [RULE9] Port output: real 18, protected 4 or 17, miss 4 or 18
// [RULE10] Bit w picks byte or full width, bit d picks transfer direction
package ivt_pkg;

  // Opcode patterns
  localparam logic [7:0] OPC_TWO_BYTE = 8'h0f;
  localparam logic [6:0] OPC_SEXT     = 7'h5f;
  localparam logic [6:0] OPC_ZEXT     = 7'h5b;
  localparam logic [6:0] OPC_GRP3     = 7'h7b;
  localparam logic [7:0] OPC_NOP      = 8'h90;
  localparam logic [5:0] OPC_OR_RM    = 6'h02;
  localparam logic [6:0] OPC_GRP1     = 7'h40;
  localparam logic [6:0] OPC_OUT_FIX  = 7'h73;
  localparam logic [6:0] OPC_OUT_VAR  = 7'h77;

  // Modrm fields
  localparam logic [2:0] REG_MUL    = 3'h4;
  localparam logic [2:0] REG_NEG    = 3'h3;
  localparam logic [2:0] REG_NOT    = 3'h2;
  localparam logic [2:0] REG_OR_IMM = 3'h1;
  localparam logic [1:0] MOD_REG    = 2'h3;

  // Operand widths
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  // Clock counts
  localparam logic [4:0] CYC_SEXT_REG      = 5'h01;
  localparam logic [4:0] CYC_SEXT_HIT      = 5'h03;
  localparam logic [4:0] CYC_SEXT_MISS     = 5'h05;
  localparam logic [4:0] CYC_ZEXT_REG      = 5'h02;
  localparam logic [4:0] CYC_ZEXT_HIT      = 5'h03;
  localparam logic [4:0] CYC_ZEXT_MISS     = 5'h05;
  localparam logic [4:0] CYC_MUL_BW_REG    = 5'h03;
  localparam logic [4:0] CYC_MUL_BW_HIT    = 5'h05;
  localparam logic [4:0] CYC_MUL_BW_MISS   = 5'h07;
  localparam logic [4:0] CYC_MUL_D_REG     = 5'h07;
  localparam logic [4:0] CYC_MUL_D_HIT     = 5'h09;
  localparam logic [4:0] CYC_MUL_D_MISS    = 5'h0d;
  localparam logic [4:0] CYC_UNARY_REG     = 5'h01;
  localparam logic [4:0] CYC_UNARY_HIT     = 5'h03;
  localparam logic [4:0] CYC_UNARY_MISS    = 5'h05;
  localparam logic [4:0] CYC_OR_RR         = 5'h01;
  localparam logic [4:0] CYC_OR_MEM_HIT    = 5'h03;
  localparam logic [4:0] CYC_OR_MEM_MISS   = 5'h05;
  localparam logic [4:0] CYC_OR_IMM_REG    = 5'h01;
  localparam logic [4:0] CYC_OR_IMM_HIT    = 5'h03;
  localparam logic [4:0] CYC_OR_IMM_MISS   = 5'h05;
  localparam logic [4:0] CYC_NOP           = 5'h03;
  localparam logic [4:0] CYC_OUT_REAL      = 5'h12;
  localparam logic [4:0] CYC_OUT_PROT_FAST = 5'h04;
  localparam logic [4:0] CYC_OUT_PROT_HIT  = 5'h11;
  localparam logic [4:0] CYC_OUT_PROT_MISS = 5'h12;
  localparam logic [4:0] CYC_ILLEGAL       = 5'h01;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [5:0]  RST_FLAGS = 6'h00;

  typedef enum logic [3:0] {
    CLS_ILLEGAL, CLS_SEXT, CLS_ZEXT, CLS_MUL, CLS_NEG,
    CLS_NOT, CLS_OR, CLS_NOP, CLS_OUT
  } ivt_cls_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_DONE = 2'h3
  } ivt_state_t;

  typedef struct packed {
    logic overflowFlag;
    logic signFlag;
    logic zeroFlag;
    logic auxFlag;
    logic parityFlag;
    logic carryFlag;
  } ivt_flags_t;

  typedef struct packed {
    logic [7:0] opcode0;
    logic [7:0] opcode1;
    logic [7:0] modrm;
  } ivt_inst_t;

  typedef struct packed {
    logic protectedMode;
    logic cacheMiss;
    logic opSize32;
    logic ioPrivileged;
  } ivt_ctx_t;

  typedef struct packed {
    ivt_cls_t   cls;
    logic [4:0] cycles;
    logic       wide;
    logic       dir;
  } ivt_dec_t;

  typedef struct packed {
    ivt_state_t  state;
    ivt_dec_t    dec;
    logic [4:0]  remain;
    ivt_ctx_t    ctx;
    logic [31:0] operandA;
    logic [31:0] operandB;
    logic [31:0] result;
    ivt_flags_t  flags;
    logic        done;
    logic        illegal;
  } ivt_core_state_t;

endpackage : ivt_pkg

//--- hw/ivt_alu.sv
/*
  Combinational result and flag unit for the decoded operations.
  Assumes operands are held stable by the caller for the whole operation.
*/
`timescale 1ns/10ps
module ivt_alu
  import ivt_pkg::*;
(
  // Operation
  input  wire ivt_cls_t   opClass,
  input  wire logic [1:0] width,
  input  wire logic       srcWide,
  // Operands
  input  wire logic [31:0] operandA,
  input  wire logic [31:0] operandB,
  input  wire ivt_flags_t  flagsIn,
  // Outcome
  output      logic [31:0] result,
  output      ivt_flags_t  flagsOut
);

  logic [31:0] mask;
  logic [31:0] a;
  logic [31:0] b;
  logic [63:0] product;
  logic [31:0] upper;
  logic        topA;
  logic        topR;

  always_comb begin
    mask = (width == WID_8) ? 32'h0000_00ff : (width == WID_16) ? 32'h0000_ffff : 32'hffff_ffff;
    a = operandA & mask;
    b = operandB & mask;
    product = {32'h0000_0000, a} * {32'h0000_0000, b};
    upper = (width == WID_8) ? {24'h00_0000, product[15:8]} :
            (width == WID_16) ? {16'h0000, product[31:16]} : product[63:32];
    result = RST_WORD;
    flagsOut = flagsIn;
    unique case (opClass)
      CLS_SEXT: begin
        result = (srcWide ? {{16{operandB[15]}}, operandB[15:0]} :
                            {{24{operandB[7]}}, operandB[7:0]}) & mask; // see [RULE1]
      end
      CLS_ZEXT: begin
        result = (srcWide ? {16'h0000, operandB[15:0]} : {24'h00_0000, operandB[7:0]}) & mask; // see [RULE2]
      end
      CLS_MUL: begin
        result = product[31:0]; // see [RULE3]
        flagsOut.overflowFlag = (upper != 32'h0000_0000);
        flagsOut.carryFlag = (upper != 32'h0000_0000);
      end
      CLS_NEG: begin
        result = (32'h0000_0000 - a) & mask; // see [RULE4]
      end
      CLS_NOT: begin
        result = ~a & mask; // see [RULE5]
      end
      CLS_OR: begin
        result = a | b; // see [RULE6]
        flagsOut.overflowFlag = 1'b0;
        flagsOut.carryFlag = 1'b0;
        flagsOut.auxFlag = 1'b0;
      end
      default: begin
        result = RST_WORD;
      end
    endcase
    topA = (width == WID_8) ? a[7] : (width == WID_16) ? a[15] : a[31];
    topR = (width == WID_8) ? result[7] : (width == WID_16) ? result[15] : result[31];
    if (opClass == CLS_NEG || opClass == CLS_OR) begin
      flagsOut.signFlag = topR; // see [RULE4]
      flagsOut.zeroFlag = (result == 32'h0000_0000);
      flagsOut.parityFlag = ~^result[7:0];
    end
    if (opClass == CLS_NEG) begin
      // Negating the most negative value yields itself: that is the overflow case
      flagsOut.carryFlag = (a != 32'h0000_0000); // see [RULE4]
      flagsOut.overflowFlag = topA & topR;
      flagsOut.auxFlag = (a[3:0] != 4'h0);
    end
  end

endmodule : ivt_alu

//--- hw/ivt_core.sv
/*
  Decoder and execution sequencer: takes one instruction, holds busy for
  its documented clock count plus one, pulsing done with result and flags in the last busy cycle.
  Assumes instruction, context and operands come from logic on core_clk
  and that the caller resolves cache hit or miss before issuing.
*/
`timescale 1ns/10ps
module ivt_core
  import ivt_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Issue
  input  wire logic        instValid,
  input  wire ivt_inst_t   instBytes,
  input  wire ivt_ctx_t    instCtx,
  input  wire logic [31:0] operandA,
  input  wire logic [31:0] operandB,
  // Status
  output      logic        busy,
  output      logic        done,
  output      logic        illegal,
  output      logic        destIsReg,
  output      ivt_cls_t    opClass,
  output      logic [4:0]  cycles,
  // Outcome
  output      logic [31:0] result,
  output      ivt_flags_t  flags
);

  function automatic logic [4:0] pick(input logic mem, input logic miss,
                                      input logic [4:0] r, input logic [4:0] h,
                                      input logic [4:0] m);
    // A cache miss only means something for a memory operand
    pick = mem ? (miss ? m : h) : r;
  endfunction : pick

  function automatic ivt_dec_t decode(input ivt_inst_t i, input ivt_ctx_t c);
    ivt_dec_t d;
    logic     mem;
    mem = (i.modrm[7:6] != MOD_REG);
    d.cls = CLS_ILLEGAL;
    d.cycles = CYC_ILLEGAL;
    d.wide = i.opcode0[0]; // see [RULE10]
    d.dir = i.opcode0[1]; // see [RULE10]
    if (i.opcode0 == OPC_TWO_BYTE && i.opcode1[7:1] == OPC_SEXT) begin
      d.cls = CLS_SEXT; // see [RULE1]
      d.wide = i.opcode1[0];
      d.dir = 1'b1;
      d.cycles = pick(mem, c.cacheMiss, CYC_SEXT_REG, CYC_SEXT_HIT, CYC_SEXT_MISS);
    end else if (i.opcode0 == OPC_TWO_BYTE && i.opcode1[7:1] == OPC_ZEXT) begin
      d.cls = CLS_ZEXT; // see [RULE2]
      d.wide = i.opcode1[0];
      d.dir = 1'b1;
      d.cycles = pick(mem, c.cacheMiss, CYC_ZEXT_REG, CYC_ZEXT_HIT, CYC_ZEXT_MISS);
    end else if (i.opcode0[7:1] == OPC_GRP3) begin
      d.dir = 1'b0;
      case (i.modrm[5:3])
        REG_MUL: begin
          d.cls = CLS_MUL; // see [RULE3]
          d.cycles = (d.wide && c.opSize32) ?
                     pick(mem, c.cacheMiss, CYC_MUL_D_REG, CYC_MUL_D_HIT, CYC_MUL_D_MISS) :
                     pick(mem, c.cacheMiss, CYC_MUL_BW_REG, CYC_MUL_BW_HIT, CYC_MUL_BW_MISS);
        end
        REG_NEG: begin
          d.cls = CLS_NEG; // see [RULE4]
          d.cycles = pick(mem, c.cacheMiss, CYC_UNARY_REG, CYC_UNARY_HIT, CYC_UNARY_MISS);
        end
        REG_NOT: begin
          d.cls = CLS_NOT; // see [RULE5]
          d.cycles = pick(mem, c.cacheMiss, CYC_UNARY_REG, CYC_UNARY_HIT, CYC_UNARY_MISS);
        end
        default: begin
          d.cls = CLS_ILLEGAL;
        end
      endcase
    end else if (i.opcode0 == OPC_NOP) begin
      d.cls = CLS_NOP;
      d.cycles = CYC_NOP;
    end else if (i.opcode0[7:2] == OPC_OR_RM) begin
      d.cls = CLS_OR; // see [RULE6]
      d.cycles = pick(mem, c.cacheMiss, CYC_OR_RR, CYC_OR_MEM_HIT, CYC_OR_MEM_MISS); // see [RULE7]
    end else if (i.opcode0[7:1] == OPC_GRP1 && i.modrm[5:3] == REG_OR_IMM) begin
      d.cls = CLS_OR; // see [RULE8]
      d.dir = 1'b0;
      d.cycles = pick(mem, c.cacheMiss, CYC_OR_IMM_REG, CYC_OR_IMM_HIT, CYC_OR_IMM_MISS);
    end else if (i.opcode0[7:1] == OPC_OUT_FIX || i.opcode0[7:1] == OPC_OUT_VAR) begin
      d.cls = CLS_OUT; // see [RULE9]
      d.dir = 1'b0;
      d.cycles = !c.protectedMode ? CYC_OUT_REAL :
                 c.ioPrivileged ? CYC_OUT_PROT_FAST :
                 c.cacheMiss ? CYC_OUT_PROT_MISS : CYC_OUT_PROT_HIT;
    end
    decode = d;
  endfunction : decode

  ivt_core_state_t s_q;
  ivt_core_state_t s_d;
  logic [1:0]      aluWidth;
  logic [31:0]     aluResult;
  ivt_flags_t      aluFlags;

  // Extending moves size the destination by operand size, the source by w
  assign aluWidth = (s_q.dec.cls == CLS_SEXT || s_q.dec.cls == CLS_ZEXT || s_q.dec.wide) ?
                    (s_q.ctx.opSize32 ? WID_32 : WID_16) : WID_8; // see [RULE10]

  ivt_alu u_alu (
    .opClass  (s_q.dec.cls),
    .width    (aluWidth),
    .srcWide  (s_q.dec.wide),
    .operandA (s_q.operandA),
    .operandB (s_q.operandB),
    .flagsIn  (s_q.flags),
    .result   (aluResult),
    .flagsOut (aluFlags)
  );

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.state)
      ST_IDLE: begin
        if (instValid) begin
          s_d.state = ST_EXEC;
          s_d.dec = decode(instBytes, instCtx);
          s_d.illegal = (s_d.dec.cls == CLS_ILLEGAL);
          s_d.remain = s_d.dec.cycles;
          s_d.ctx = instCtx;
          s_d.operandA = operandA;
          s_d.operandB = operandB;
        end
      end
      ST_EXEC: begin
        s_d.remain = s_q.remain - 5'h01;
        if (s_q.remain == 5'h01) begin
          s_d.state = ST_DONE;
          s_d.done = 1'b1;
          s_d.result = aluResult;
          s_d.flags = aluFlags;
        end
      end
      ST_DONE: begin
        // Busy stays high in the done cycle, which keeps issue and completion apart
        s_d.state = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{state: ST_IDLE, dec: '{cls: CLS_ILLEGAL, cycles: CYC_ILLEGAL, wide: 1'b0,
               dir: 1'b0}, remain: 5'h00, ctx: 4'h0, operandA: RST_WORD,
               operandB: RST_WORD, result: RST_WORD, flags: RST_FLAGS, done: 1'b0,
               illegal: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Both busy states carry bit 0, so busy needs no gate after the flop
  assign busy = s_q.state[0];
  assign done = s_q.done;
  assign illegal = s_q.illegal;
  assign destIsReg = s_q.dec.dir;
  assign opClass = s_q.dec.cls;
  assign cycles = s_q.dec.cycles;
  assign result = s_q.result;
  assign flags = s_q.flags;

  // Helper: cycles spent in execution, checked against the decoded count
  logic [4:0] execCnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      execCnt <= 5'h00;
    end else if (s_q.state == ST_EXEC) begin
      execCnt <= execCnt + 5'h01;
    end else begin
      execCnt <= 5'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic issue;
  logic memIn;
  assign issue = (s_q.state == ST_IDLE) && instValid;
  assign memIn = (instBytes.modrm[7:6] != MOD_REG);

  a_sext_timing: assert property (issue && instBytes.opcode0 == 8'h0f && // see [RULE1]
    instBytes.opcode1[7:1] == 7'h5f |=> opClass == CLS_SEXT &&
    cycles == $past(!memIn ? 5'h01 : instCtx.cacheMiss ? 5'h05 : 5'h03))
    else $error("sign extend clock count wrong");
  a_zext_timing: assert property (issue && instBytes.opcode0 == 8'h0f && // see [RULE2]
    instBytes.opcode1[7:1] == 7'h5b |=> opClass == CLS_ZEXT &&
    cycles == $past(!memIn ? 5'd2 : instCtx.cacheMiss ? 5'd5 : 5'd3))
    else $error("zero extend clock count wrong");
  a_mul_dword: assert property (issue && instBytes.opcode0 == 8'hf7 && // see [RULE3]
    instBytes.modrm[5:3] == 3'h4 && instCtx.opSize32 && memIn && instCtx.cacheMiss
    |=> cycles == 5'd13 ##13 done)
    else $error("doubleword multiply timing wrong");
  a_neg_flags: assert property (done && opClass == CLS_NEG |-> // see [RULE4]
    flags.zeroFlag == (result == 32'h0) && flags.carryFlag == !flags.zeroFlag)
    else $error("negate flags wrong");
  a_not_invert: assert property (done && opClass == CLS_NOT && aluWidth == WID_32 |-> // see [RULE5]
    result == ~s_q.operandA)
    else $error("complement result wrong");
  a_or_flags: assert property (done && opClass == CLS_OR |-> // see [RULE6]
    !flags.overflowFlag && !flags.carryFlag && flags.zeroFlag == (result == 32'h0))
    else $error("boolean or flags wrong");
  a_or_memory: assert property (issue && instBytes.opcode0[7:2] == 6'h02 && memIn // see [RULE7]
    |=> cycles == $past(instCtx.cacheMiss ? 5'd5 : 5'd3))
    else $error("or memory timing wrong");
  a_or_imm: assert property (issue && instBytes.opcode0[7:1] == 7'h40 && // see [RULE8]
    instBytes.modrm[5:3] == 3'h1 && !memIn |=> opClass == CLS_OR ##1 done)
    else $error("or immediate register timing wrong");
  a_out_real: assert property (issue && instBytes.opcode0[7:1] == 7'h77 && // see [RULE9]
    !instCtx.protectedMode |=> cycles == 5'h12 && busy ##17 busy && !done ##1 done)
    else $error("real mode port output timing wrong");
  a_width_bit: assert property (issue && instBytes.opcode0 != 8'h0f |=> // see [RULE10]
    s_q.dec.wide == $past(instBytes.opcode0[0]))
    else $error("width bit not taken from opcode");
  a_done_count: assert property (done |-> $past(execCnt) == cycles - 5'h01 ##1 !busy) // see [RULE1]
    else $error("execution length differs from decoded count");

  c_mul_done: cover property (done && opClass == CLS_MUL);
  c_out_prot: cover property (done && opClass == CLS_OUT && s_q.ctx.protectedMode);
  c_neg_overflow: cover property (done && opClass == CLS_NEG && flags.overflowFlag);
  c_illegal: cover property (done && illegal);

endmodule : ivt_core

//--- testbench/testbench.sv
/*
  Self-checking bench for the decode and timing core: drives issues at the
  falling edge, then checks latency, decoded class, result and flags.
  Assumes ivt_pkg is compiled first and ivt_core is the block under test.
*/
`timescale 1ns/10ps
module testbench
  import ivt_pkg::*;
;
  logic        core_clk;
  logic        rstn;
  logic        instValid;
  ivt_inst_t   instBytes;
  ivt_ctx_t    instCtx;
  logic [31:0] operandA;
  logic [31:0] operandB;
  logic        busy;
  logic        done;
  logic        illegal;
  logic        destIsReg;
  ivt_cls_t    opClass;
  logic [4:0]  cycles;
  logic [31:0] result;
  ivt_flags_t  flags;
  int          err_count;
  int          checks;
  int          cycleCount;
  logic [31:0] rngState;
  logic [5:0]  expFlags;

  ivt_core ivt_core_inst (
    .core_clk (core_clk), .rstn (rstn), .instValid (instValid), .instBytes (instBytes),
    .instCtx (instCtx), .operandA (operandA), .operandB (operandB), .busy (busy),
    .done (done), .illegal (illegal), .destIsReg (destIsReg), .opClass (opClass),
    .cycles (cycles), .result (result), .flags (flags)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == 30000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] xorshift();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : xorshift

  function automatic void decode(input logic [7:0] o0, o1, m, input logic [3:0] cx,
                                 output ivt_cls_t c, output logic [4:0] n);
    logic mem;
    logic miss;
    mem  = (m[7:6] != 2'h3);
    miss = cx[2];
    c = CLS_ILLEGAL;
    n = 5'h01;
    if (o0 == 8'h0f && (o1 == 8'hbe || o1 == 8'hbf)) begin
      c = CLS_SEXT;
      n = mem ? (miss ? 5'h05 : 5'h03) : 5'h01;
    end else if (o0 == 8'h0f && (o1 == 8'hb6 || o1 == 8'hb7)) begin
      c = CLS_ZEXT;
      n = mem ? (miss ? 5'h05 : 5'h03) : 5'h02;
    end else if (o0[7:1] == 7'h7b && m[5:3] == 3'h4) begin
      c = CLS_MUL;
      if (o0[0] && cx[1]) n = mem ? (miss ? 5'h0d : 5'h09) : 5'h07;
      else n = mem ? (miss ? 5'h07 : 5'h05) : 5'h03;
    end else if (o0[7:1] == 7'h7b && (m[5:3] == 3'h3 || m[5:3] == 3'h2)) begin
      c = (m[5:3] == 3'h3) ? CLS_NEG : CLS_NOT;
      n = mem ? (miss ? 5'h05 : 5'h03) : 5'h01;
    end else if (o0 == 8'h90) begin
      c = CLS_NOP;
      n = 5'h03;
    end else if (o0[7:2] == 6'h02 || (o0[7:1] == 7'h40 && m[5:3] == 3'h1)) begin
      c = CLS_OR;
      n = mem ? (miss ? 5'h05 : 5'h03) : 5'h01;
    end else if (o0 == 8'he6 || o0 == 8'he7 || o0 == 8'hee || o0 == 8'hef) begin
      c = CLS_OUT;
      n = !cx[3] ? 5'h12 : (cx[0] ? 5'h04 : (miss ? 5'h12 : 5'h11));
    end
  endfunction : decode

  // Result of one operation; expFlags follows the flag effects
  function automatic logic [31:0] calc(input ivt_cls_t c, input logic [7:0] o0, o1,
                                       input logic [3:0] cx, input logic [31:0] a, b);
    logic [31:0] mk;
    logic [31:0] r;
    logic [63:0] p;
    int          hi;
    mk = !o0[0] ? 32'h0000_00ff : (cx[1] ? 32'hffff_ffff : 32'h0000_ffff);
    hi = !o0[0] ? 7 : (cx[1] ? 31 : 15);
    r = 32'h0000_0000;
    case (c)
      CLS_OR:  r = (a | b) & mk;
      CLS_NEG: r = (-a) & mk;
      CLS_NOT: r = ~a & mk;
      CLS_MUL: begin
        p = {32'h0, a & mk} * {32'h0, b & mk};
        r = p[31:0];
        expFlags[5] = !o0[0] ? (p[15:8] != 0) : (cx[1] ? (p[63:32] != 0) : (p[31:16] != 0));
        expFlags[0] = expFlags[5];
      end
      CLS_SEXT: r = (o1[0] ? {{16{b[15]}}, b[15:0]} : {{24{b[7]}}, b[7:0]})
                    & (cx[1] ? 32'hffff_ffff : 32'h0000_ffff);
      CLS_ZEXT: r = o1[0] ? {16'h0, b[15:0]} : {24'h0, b[7:0]};
      default: r = 32'h0000_0000;
    endcase
    if (c == CLS_OR) expFlags = {1'b0, r[hi], r == 0, 1'b0, ~^r[7:0], 1'b0};
    if (c == CLS_NEG) begin
      expFlags = {(a & mk) == ((mk >> 1) + 1), r[hi], r == 0, a[3:0] != 0, ~^r[7:0],
                  (a & mk) != 0};
    end
    return r;
  endfunction : calc

  task automatic issue(input logic [7:0] o0, o1, m, input logic [3:0] cx,
                       input logic [31:0] a, b, input bit intrude);
    int          n;
    ivt_cls_t    ec;
    logic [4:0]  en;
    logic [31:0] er;
    decode(o0, o1, m, cx, ec, en);
    er = calc(ec, o0, o1, cx, a, b);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    instBytes = {o0, o1, m};
    instCtx   = cx;
    operandA  = a;
    operandB  = b;
    instValid = 1'b1;
    @(negedge core_clk);
    check("busy", busy, 1);
    check("cycles", cycles, en);
    check("opClass", opClass, ec);
    check("illegal", illegal, ec == CLS_ILLEGAL);
    if (o0[7:2] == 6'h02) check("destIsReg", destIsReg, o0[1]);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      // A request while busy must be ignored
      instBytes = 24'h09_00_c1;
      instValid = intrude && n == 2;
      @(negedge core_clk);
      n++;
    end
    instValid = 1'b0;
    check("latency", n, en);
    check("result", result, er);
    check("flags", flags, expFlags);
    check("classKept", opClass, ec);
    @(negedge core_clk);
    check("busyAfter", busy, 0);
  endtask : issue

  task automatic do_reset();
    rstn = 1'b0;
    expFlags = 6'h00;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
  endtask : do_reset

  initial begin
    logic [31:0] r;
    logic [7:0]  o0;
    logic [7:0]  ops [16];
    ops = '{8'h0f, 8'hf6, 8'hf7, 8'h90, 8'h08, 8'h09, 8'h0a, 8'h0b,
            8'h80, 8'h81, 8'he6, 8'he7, 8'hee, 8'hef, 8'h00, 8'hf7};
    {instValid, instBytes, instCtx, operandA, operandB} = '0;
    rstn = 1'b0;
    rngState = 32'h1489;
    err_count = 0;
    checks = 0;
    cycleCount = 0;
    do_reset();
    issue(8'h09, 8'h00, 8'hc1, 4'h0, 32'h0f0f_0000, 32'h0000_00f0, 0);
    issue(8'h08, 8'h00, 8'hc0, 4'h0, 32'h0000_0000, 32'h0000_0000, 0);
    issue(8'h0b, 8'h00, 8'h05, 4'h4, 32'h1234_5678, 32'h8000_0001, 0);
    issue(8'h08, 8'h00, 8'h45, 4'h0, 32'h0000_0011, 32'h0000_0022, 0);
    issue(8'hf6, 8'h00, 8'hd8, 4'h0, 32'h0000_0080, 32'h0, 0);
    issue(8'hf7, 8'h00, 8'hd8, 4'h2, 32'h0000_0000, 32'h0, 0);
    issue(8'hf7, 8'h00, 8'h20, 4'h6, 32'hffff_ffff, 32'hffff_ffff, 0);
    issue(8'hf6, 8'h00, 8'he0, 4'h0, 32'h0000_00ff, 32'h0000_00ff, 0);
    issue(8'hf7, 8'h00, 8'h20, 4'h0, 32'h0000_ffff, 32'h0000_0002, 0);
    issue(8'hf7, 8'h00, 8'hd0, 4'h2, 32'h0f0f_1234, 32'h0, 0);
    issue(8'h0f, 8'hbe, 8'hc0, 4'h2, 32'h0, 32'h0000_0080, 0);
    issue(8'h0f, 8'hb7, 8'h00, 4'h4, 32'h0, 32'hffff_8001, 0);
    issue(8'h81, 8'h00, 8'hc8, 4'h2, 32'h8000_0000, 32'h0000_0001, 0);
    issue(8'h80, 8'h00, 8'h08, 4'h0, 32'h0000_0001, 32'h0000_0002, 0);
    issue(8'h90, 8'h00, 8'h00, 4'h0, 32'h0, 32'h0, 0);
    issue(8'hee, 8'h00, 8'h00, 4'h0, 32'h0, 32'h0, 1);
    issue(8'hef, 8'h00, 8'h00, 4'h8, 32'h0, 32'h0, 0);
    issue(8'he6, 8'h00, 8'h00, 4'h9, 32'h0, 32'h0, 0);
    issue(8'he7, 8'h00, 8'h00, 4'hc, 32'h0, 32'h0, 0);
    issue(8'hf6, 8'h00, 8'hc0, 4'h0, 32'h0, 32'h0, 0);
    do_reset();
    issue(8'hf6, 8'h00, 8'hd1, 4'h0, 32'h0000_005a, 32'h0, 0);
    // Random mix; modrm reg field also lands on undecoded group members
    for (int i = 0; i < 200; i++) begin
      r  = xorshift();
      o0 = ops[r[3:0]];
      issue(o0, {4'hb, r[4], 2'h3, r[5]}, r[15:8], r[19:16], xorshift(), xorshift(), 0);
    end
    stop_test();
  end

endmodule : testbench
